// File: rtl/crr_pkg.sv
// Purpose: shared constants for the clock ratio and reset release block
// Assumes: 32-bit classic wishbone register bus, byte addresses
// Notes:   all offsets, fields, reset values and counts live here
package crr_pkg;

	// ==========================================================
	// register map (byte addresses, one aligned word each)
	// ==========================================================
	localparam logic [7:0] OFS_PWR_MGMT_CTRL = 8'h00; // ratio override
	localparam logic [7:0] OFS_SPI_DIVIDER   = 8'h04; // spi ratio
	localparam logic [7:0] OFS_STATUS        = 8'h08; // read only state
	localparam logic [7:0] OFS_SERIAL_BASE   = 8'h10; // port n at +4n

	// ==========================================================
	// power management control fields
	// ==========================================================
	localparam int PMC_OVR_BIT   = 0; // 1: software ratio wins over pins if two or more
	localparam int PMC_RATIO_LSB = 1; // software core:input multiplier
	localparam int PMC_RATIO_W   = 6;

	// ==========================================================
	// status fields
	// ==========================================================
	localparam int STS_CORE_RUN_BIT = 0; // core reset released
	localparam int STS_PINS_LSB     = 1; // captured ratio select pins
	localparam int STS_RATIO_LSB    = 4; // active multiplier

	// ==========================================================
	// reset values and ratios
	// ==========================================================
	localparam logic [5:0]  RATIO_SEL_00  = 6'h06; // 6:1
	localparam logic [5:0]  RATIO_SEL_01  = 6'h20; // 32:1
	localparam logic [5:0]  RATIO_SEL_10  = 6'h10; // 16:1
	localparam logic [5:0]  RATIO_SEL_11  = 6'h06; // 6:1
	localparam logic [5:0]  PMC_RATIO_RST = 6'h10;
	localparam logic [15:0] DIV_RST       = 16'h0001;
	localparam int          PCLK_DIV      = 2; // core cycles per pclk

	// ==========================================================
	// reset release timing
	// ==========================================================
	localparam int CORE_RST_IN_CYCLES   = 4096; // input clock cycles
	localparam int CORE_RST_CORE_CYCLES = 2;    // trailing core cycles

endpackage : crr_pkg

// File: rtl/crr_divider.sv
// Purpose: programmable tick divider, one output pulse per ratio ticks
// Assumes: i_tick is a one-cycle enable on i_clk
// Notes:   a ratio of zero behaves as one
`timescale 1ns/1ps
`default_nettype none
module crr_divider #(
	parameter int W = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_tick,  // source rate enable
	input  wire logic [W-1:0] i_ratio, // divide ratio
	output logic              o_tick   // divided enable, registered
);
	initial begin
		if (W < 2) $error("crr_divider: W must be at least 2");
	end

	// ==========================================================
	// state
	// ==========================================================
	typedef struct packed {
		logic [W-1:0] cnt; // source ticks seen this period
		logic         out; // pulse register
	} crr_div_t;

	crr_div_t st;      // registered state
	crr_div_t next_st; // next state

	// count source ticks and fire at the end of each period
	always_comb begin
		next_st     = st;
		next_st.out = 1'b0;
		if (i_tick) begin
			if (st.cnt + 1'b1 >= i_ratio) begin
				next_st.cnt = '0;
				next_st.out = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end
	end

	// register the state
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_tick = st.out;
endmodule : crr_divider
`default_nettype wire

// File: rtl/crr_top.sv
// Purpose: core/input clock ratio, derived rate enables, core reset release
// Assumes: i_clk is the core clock; input clock is modelled as an enable
// Notes:   wishbone classic slave for ratio and divider registers
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - peripheral period is two core periods
// - serial clock is peripheral times port ratio
// - spi clock is peripheral times spi ratio
// - ratio pins held and sampled during reset
// - core multiple 6, 16, 32 or software
// - core reset released 4096 input plus two
// - late reset release may add one cycle
module crr_top
	import crr_pkg::*;
#(
	parameter int NUM_SPORT     = 2,
	parameter int DIV_W         = 16,
	parameter int RST_IN_CYCLES = CORE_RST_IN_CYCLES
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_reset_pin_n,     // external reset
	input  wire logic [1:0]           i_ratio_select_pins,
	input  wire logic                 i_wb_cyc,
	input  wire logic                 i_wb_stb,
	input  wire logic                 i_wb_we,
	input  wire logic [7:0]           i_wb_adr,
	input  wire logic [31:0]          i_wb_dat,
	input  wire logic [3:0]           i_wb_sel,
	output logic [31:0]               o_wb_dat,
	output logic                      o_wb_ack,
	output logic                      o_core_rst_n,      // internal reset
	output logic                      o_input_clock_en,  // input clk tick
	output logic                      o_pclk_en,         // peripheral tick
	output logic [NUM_SPORT-1:0]      o_serial_clk_en,   // per port
	output logic                      o_spi_serial_clk_en
);
	initial begin
		if (NUM_SPORT < 1 || NUM_SPORT > 8)
			$error("crr_top: NUM_SPORT must be 1..8");
		if (DIV_W < 2 || DIV_W > 32)
			$error("crr_top: DIV_W must be 2..32");
		if (RST_IN_CYCLES < 2 || RST_IN_CYCLES > 65535)
			$error("crr_top: RST_IN_CYCLES must be 2..65535");
	end

	// ==========================================================
	// state types
	// ==========================================================
	typedef enum logic [1:0] {
		RS_HOLD, // external reset low, counter cleared
		RS_COUNT, // counting input clock cycles
		RS_TAIL, // trailing core cycles
		RS_RUN // core out of reset
	} crr_rst_state_t;

	typedef struct packed {
		crr_rst_state_t              rs;       // reset release phase
		logic [16:0]                 in_cnt;   // input cycles counted
		logic [1:0]                  tail_cnt; // core cycles after count
		logic [1:0]                  pins;     // captured ratio pins
		logic [5:0]                  div_cnt;  // core cycles in input clk
		logic                        in_en;    // input clock tick
		logic                        pclk_ph;  // peripheral phase
		logic                        pclk_en;  // peripheral tick
		logic                        core_rst_n;
		logic                        pmc_ovr;  // software ratio enable
		logic [PMC_RATIO_W-1:0]      pmc_ratio;
		logic [DIV_W-1:0]            spi_div;
		logic [NUM_SPORT-1:0][DIV_W-1:0] ser_div;
		logic                        ack;
		logic [31:0]                 rdat;
	} crr_state_t;

	crr_state_t st;      // registered state
	crr_state_t next_st; // next state

	// ==========================================================
	// ratio selection
	// ==========================================================
	logic [5:0] pin_ratio;    // multiplier from captured pins
	logic [5:0] active_ratio; // multiplier in force

	// decode the pins captured during reset
	always_comb begin
		case (st.pins)
			2'b00:   pin_ratio = RATIO_SEL_00;
			2'b01:   pin_ratio = RATIO_SEL_01;
			2'b10:   pin_ratio = RATIO_SEL_10;
			2'b11:   pin_ratio = RATIO_SEL_11;
			default: pin_ratio = RATIO_SEL_00;
		endcase
	end

	// software ratio overrides pins; values below two are unusable
	always_comb begin
		if (st.pmc_ovr && st.pmc_ratio >= 6'h02) begin
			active_ratio = st.pmc_ratio;
		end else begin
			active_ratio = pin_ratio;
		end
	end

	// ==========================================================
	// bus decode
	// ==========================================================
	logic        bus_req;  // new request this cycle
	logic [31:0] wmask;    // byte lane mask
	logic [31:0] status;   // status word
	logic [7:0]  ser_ofs;  // offset within serial block
	logic [2:0]  ser_idx;  // serial port addressed
	logic        ser_hit;  // address lands on a serial divider

	assign bus_req = i_wb_cyc && i_wb_stb && !st.ack;
	assign wmask   = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
		{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	assign ser_ofs = i_wb_adr - OFS_SERIAL_BASE;
	assign ser_idx = ser_ofs[4:2];
	assign ser_hit = (i_wb_adr >= OFS_SERIAL_BASE) &&
		(ser_ofs[1:0] == 2'b00) &&
		(32'(ser_ofs[7:2]) < NUM_SPORT);

	// live status: run flag, captured pins, active multiplier
	always_comb begin
		status                   = '0;
		status[STS_CORE_RUN_BIT] = st.core_rst_n;
		status[STS_PINS_LSB+:2]  = st.pins;
		status[STS_RATIO_LSB+:6] = active_ratio;
	end

	// ==========================================================
	// next state
	// ==========================================================
	logic [31:0] wval; // merged write value scratch

	// one process computes all state transitions
	always_comb begin
		next_st         = st;
		wval            = '0;
		next_st.in_en   = 1'b0;
		next_st.pclk_en = 1'b0;
		next_st.ack     = 1'b0;

		// input clock tick: one per active_ratio core cycles
		// the >= compare absorbs a ratio change in mid period, so the
		// first period after a change may be short but never hangs
		if (st.div_cnt + 6'h01 >= active_ratio) begin
			next_st.div_cnt = '0;
			next_st.in_en   = 1'b1;
		end else begin
			next_st.div_cnt = st.div_cnt + 6'h01;
		end

		// peripheral tick every second core cycle
		next_st.pclk_ph = ~st.pclk_ph;
		if (st.pclk_ph) begin
			next_st.pclk_en = 1'b1;
		end

		// reset release sequence
		// the count runs on input clock ticks, not core cycles, so the
		// delay scales with the ratio in force; the ratio pins are
		// frozen once the pin is seen high, which keeps the count and
		// the multiplier steady while the core waits
		case (st.rs)
			RS_HOLD: begin
				next_st.in_cnt     = '0;
				next_st.tail_cnt   = '0;
				next_st.core_rst_n = 1'b0;
				// pins are sampled continuously while reset is low
				if (!i_reset_pin_n) begin
					next_st.pins = i_ratio_select_pins;
				end else if (st.in_en) begin
					// first input edge that sees the pin high counts;
					// a release just after an edge waits a whole extra
					// input cycle for the next one
					next_st.in_cnt = 17'h00001;
					next_st.rs     = RS_COUNT;
				end
			end
			RS_COUNT: begin
				if (st.in_en) begin
					if (32'(st.in_cnt) >= RST_IN_CYCLES) begin
						next_st.rs = RS_TAIL;
					end else begin
						next_st.in_cnt = st.in_cnt + 17'h00001;
					end
				end
			end
			RS_TAIL: begin
				if (32'(st.tail_cnt) + 1 >= CORE_RST_CORE_CYCLES) begin
					next_st.rs         = RS_RUN;
					next_st.core_rst_n = 1'b1;
				end else begin
					next_st.tail_cnt = st.tail_cnt + 2'h1;
				end
			end
			RS_RUN: begin
				next_st.core_rst_n = 1'b1;
			end
			default: begin
				next_st.rs = RS_HOLD;
			end
		endcase
		// a low reset pin always restarts the sequence
		if (!i_reset_pin_n) begin
			next_st.rs         = RS_HOLD;
			next_st.in_cnt     = '0;
			next_st.core_rst_n = 1'b0;
			next_st.pins       = i_ratio_select_pins;
		end

		// register bus: one wait-free answer per request
		// the write lands on the edge that takes the request and the
		// acknowledge rises on that same edge; a held strobe is not
		// taken twice because the pending acknowledge masks it
		if (bus_req) begin
			next_st.ack  = 1'b1;
			next_st.rdat = '0;
			if (i_wb_adr == OFS_PWR_MGMT_CTRL) begin
				wval = {25'h0, st.pmc_ratio, st.pmc_ovr};
				next_st.rdat = wval;
				if (i_wb_we) begin
					wval = (wval & ~wmask) | (i_wb_dat & wmask);
					next_st.pmc_ovr   = wval[PMC_OVR_BIT];
					next_st.pmc_ratio = wval[PMC_RATIO_LSB+:PMC_RATIO_W];
				end
			end else if (i_wb_adr == OFS_SPI_DIVIDER) begin
				wval = 32'(st.spi_div);
				next_st.rdat = wval;
				if (i_wb_we) begin
					wval = (wval & ~wmask) | (i_wb_dat & wmask);
					next_st.spi_div = wval[DIV_W-1:0];
				end
			end else if (i_wb_adr == OFS_STATUS) begin
				next_st.rdat = status; // writes ignored
			end else if (ser_hit) begin
				wval = 32'(st.ser_div[ser_idx]);
				next_st.rdat = wval;
				if (i_wb_we) begin
					wval = (wval & ~wmask) | (i_wb_dat & wmask);
					next_st.ser_div[ser_idx] = wval[DIV_W-1:0];
				end
			end
		end
	end

	// ==========================================================
	// state register
	// ==========================================================
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st            <= '0;
			st.rs         <= RS_HOLD;
			st.pmc_ratio  <= PMC_RATIO_RST;
			st.spi_div    <= DIV_W'(DIV_RST);
			st.ser_div    <= {NUM_SPORT{DIV_W'(DIV_RST)}};
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// port and spi dividers, fed from the peripheral tick
	// ==========================================================
	// all dividers share the peripheral tick, so every derived rate
	// stays aligned to it; a ratio change applies from the count
	// already reached, so one period may come out short
	crr_divider #(.W(DIV_W)) u_spi_div (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_tick  (st.pclk_en),
		.i_ratio (st.spi_div),
		.o_tick  (o_spi_serial_clk_en)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SPORT; gi++) begin : g_ser
			crr_divider #(.W(DIV_W)) u_ser_div (
				.i_clk   (i_clk),
				.i_rst_n (i_rst_n),
				.i_tick  (st.pclk_en),
				.i_ratio (st.ser_div[gi]),
				.o_tick  (o_serial_clk_en[gi])
			);
		end
	endgenerate

	// ==========================================================
	// outputs, all from flops
	// ==========================================================
	assign o_wb_dat         = st.rdat;
	assign o_wb_ack         = st.ack;
	assign o_core_rst_n     = st.core_rst_n;
	assign o_input_clock_en = st.in_en;
	assign o_pclk_en        = st.pclk_en;
endmodule : crr_top
`default_nettype wire

// File: verif/crr_monitor.sv
// Purpose: concurrent checks on the crr_top ports
// Assumes: one clock; input clock seen as its enable pulse
// Notes:   ratio check skips the first period after a ratio change
`timescale 1ns/1ps
`default_nettype none
module crr_monitor
	import crr_pkg::*;
#(
	parameter int NUM_SPORT     = 2,
	parameter int RST_IN_CYCLES = 8
) (
	input wire logic                 i_clk,
	input wire logic                 i_rst_n,
	input wire logic                 i_reset_pin_n,
	input wire logic [1:0]           i_ratio_select_pins,
	input wire logic                 i_wb_cyc,
	input wire logic                 i_wb_stb,
	input wire logic                 i_wb_we,
	input wire logic [7:0]           i_wb_adr,
	input wire logic [31:0]          i_wb_dat,
	input wire logic [3:0]           i_wb_sel,
	input wire logic [31:0]          o_wb_dat,
	input wire logic                 o_wb_ack,
	input wire logic                 o_core_rst_n,
	input wire logic                 o_input_clock_en,
	input wire logic                 o_pclk_en,
	input wire logic [NUM_SPORT-1:0] o_serial_clk_en,
	input wire logic                 o_spi_serial_clk_en
);
	// ==========================================================
	// shadow of the ratio choice and the release count
	// ==========================================================
	logic [1:0]  pcap;  // pins seen while reset pin low
	logic        ovr;   // software override flag
	logic [5:0]  sw;    // software multiplier
	logic [5:0]  exp_c; // ratio expected now
	logic [5:0]  exp_q; // ratio of last cycle
	logic [7:0]  gap;   // core cycles since last input tick
	logic        armed; // a full period at a steady ratio is running
	logic [15:0] ticks; // input ticks since reset pin high
	// software multipliers below two fall back to the pins
	always_comb begin
		exp_c = (pcap == 2'b01) ? 6'h20 : (pcap == 2'b10) ? 6'h10 : 6'h06;
		if (ovr && sw > 6'h01) begin
			exp_c = sw;
		end
	end
	// shadow registers follow only what the bus and pins show
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pcap  <= 2'b00;
			ovr   <= 1'b0;
			sw    <= PMC_RATIO_RST;
			exp_q <= 6'h06;
			gap   <= 8'h00;
			armed <= 1'b0;
			ticks <= 16'h0000;
		end else begin
			if (!i_reset_pin_n) begin
				pcap <= i_ratio_select_pins;
			end
			if (o_wb_ack && i_wb_we && i_wb_sel[0] &&
					i_wb_adr == OFS_PWR_MGMT_CTRL) begin
				ovr <= i_wb_dat[0];
				sw  <= i_wb_dat[6:1];
			end
			exp_q <= exp_c;
			gap   <= o_input_clock_en ? 8'h00 : gap + 8'h01;
			armed <= (exp_c == exp_q) && (armed || o_input_clock_en);
			ticks <= !i_reset_pin_n ? 16'h0000 :
				ticks + {15'h0000, o_input_clock_en};
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================================
	// assertions
	// ==========================================================
	pclk_period_a: assert property (
		o_pclk_en |=> !o_pclk_en ##1 o_pclk_en) else $error("pclk period");
	serial_gap_a: assert property (
		|o_serial_clk_en |=> (o_serial_clk_en & $past(o_serial_clk_en)) == '0)
		else $error("serial pulse too close");
	spi_gap_a: assert property (
		o_spi_serial_clk_en |=> !o_spi_serial_clk_en) else $error("spi gap");
	ratio_period_a: assert property (
		o_input_clock_en && armed && exp_c == exp_q |->
		gap == {2'b00, exp_q} - 8'h01) else $error("input tick period");
	core_release_a: assert property (
		$rose(o_core_rst_n) |-> ticks >= RST_IN_CYCLES &&
		ticks <= RST_IN_CYCLES + 2) else $error("core release count");
	pin_holds_a: assert property (
		!i_reset_pin_n [*2] |-> !o_core_rst_n) else $error("core not held");
	ack_once_a: assert property (
		o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
	ack_answer_a: assert property (
		i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
	unmapped_zero_a: assert property (
		o_wb_ack && !i_wb_we && i_wb_adr == 8'h0c |-> o_wb_dat == '0)
		else $error("unmapped read not zero");
	release_seen_c: cover property ($rose(o_core_rst_n));
	spi_seen_c: cover property (o_spi_serial_clk_en);
	write_seen_c: cover property (o_wb_ack && i_wb_we);
endmodule : crr_monitor
bind crr_top crr_monitor #(.NUM_SPORT(NUM_SPORT),
	.RST_IN_CYCLES(RST_IN_CYCLES)) u_crr_monitor (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_reset_pin_n(i_reset_pin_n),
	.i_ratio_select_pins(i_ratio_select_pins), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat),
	.o_wb_ack(o_wb_ack), .o_core_rst_n(o_core_rst_n),
	.o_input_clock_en(o_input_clock_en), .o_pclk_en(o_pclk_en),
	.o_serial_clk_en(o_serial_clk_en),
	.o_spi_serial_clk_en(o_spi_serial_clk_en));
`default_nettype wire

// File: verif/crr_board.sv
// Purpose: board reset supervisor and ratio pin source
// Assumes: i_tick is the modelled input clock
// Notes:   settle times are scaled into the hold count
`timescale 1ns/1ps
`default_nettype none
module crr_board #(
	parameter int HOLD = 6 // input ticks of reset low, four at least
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_tick,
	input  wire logic       i_req,
	input  wire logic [1:0] i_pins,
	output logic            o_reset_pin_n,
	output logic [1:0]      o_pins
);
	logic [7:0] cnt; // ticks spent in reset
	logic       rel; // reset just released
	// pins are only promised while reset is low, so they flip after
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reset_pin_n <= 1'b0;
			o_pins        <= i_pins;
			cnt           <= 8'h00;
			rel           <= 1'b0;
		end else begin
			rel <= 1'b0;
			if (i_req) begin
				o_reset_pin_n <= 1'b0;
				o_pins        <= i_pins;
				cnt           <= 8'h00;
			end else if (!o_reset_pin_n) begin
				cnt <= cnt + {7'h00, i_tick};
				if (cnt >= HOLD) begin
					o_reset_pin_n <= 1'b1;
					rel           <= 1'b1;
				end
			end else if (rel) begin
				o_pins <= ~o_pins;
			end
		end
	end
endmodule : crr_board
`default_nettype wire

// File: verif/crr_top_tb.sv
// Purpose: self-checking bench for crr_top
// Assumes: core reset count shortened to eight input ticks
// Notes:   period checks skip the first gap after a change
`timescale 1ns/1ps
`default_nettype none
module crr_top_tb;
	import crr_pkg::*;
	localparam int N = 8;
	logic clk = 1'b0, rst_n = 1'b0, rpin_n, req = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, core_n, in_en, pclk, spi;
	logic [1:0] pins, rqp = 2'b00, ser;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic [4:0] en_v;
	int fails = 0, tests_run = 0;
	int rt[4] = '{6, 32, 16, 6};
	assign en_v = {spi, ser, pclk, in_en};
	crr_top #(.NUM_SPORT(2), .DIV_W(16), .RST_IN_CYCLES(N)) u_crr_top (
		.i_clk(clk), .i_rst_n(rst_n), .i_reset_pin_n(rpin_n),
		.i_ratio_select_pins(pins), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
		.o_wb_dat(rdat), .o_wb_ack(ack), .o_core_rst_n(core_n),
		.o_input_clock_en(in_en), .o_pclk_en(pclk), .o_serial_clk_en(ser),
		.o_spi_serial_clk_en(spi));
	crr_board #(.HOLD(6)) u_crr_board (.i_clk(clk), .i_rst_n(rst_n),
		.i_tick(in_en), .i_req(req), .i_pins(rqp), .o_reset_pin_n(rpin_n),
		.o_pins(pins));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic complete_run;
		if (fails == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rng(input string nm, input int lo, hi, g);
		tests_run++;
		if (g < lo || g > hi) begin
			fails++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : rng
	// classic cycle; request held until the edge that samples ack high,
	// data taken at that edge; only the watchdog ends a hang
	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic wpulse(input int i, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (en_v[i] !== 1'b1 && n < 2000);
	endtask : wpulse
	task automatic per(input int i, input int e, input string nm);
		int n;
		wpulse(i, n);
		wpulse(i, n);
		wpulse(i, n);
		chk(nm, e, n);
	endtask : per
	task automatic t_regs;
		logic [31:0] q;
		int          n;
		wb(1'b0, OFS_STATUS, 32'h0, q);
		chk("status held", 32'h0, {31'h0, q[0]});
		wb(1'b0, OFS_PWR_MGMT_CTRL, 32'h0, q);
		chk("pmc reset", {25'h0, PMC_RATIO_RST, 1'b0}, q);
		wb(1'b0, OFS_SPI_DIVIDER, 32'h0, q);
		chk("spi div reset", {16'h0, DIV_RST}, q);
		wb(1'b0, OFS_SERIAL_BASE + 8'h04, 32'h0, q);
		chk("serial div reset", {16'h0, DIV_RST}, q);
		wb(1'b1, 8'h0c, 32'hffffffff, q);
		wb(1'b0, 8'h0c, 32'h0, q);
		chk("unmapped", 32'h0, q);
		n = 0;
		while (core_n !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		wb(1'b1, OFS_STATUS, 32'h0, q);
		wb(1'b0, OFS_STATUS, 32'h0, q);
		chk("status run bit", 32'h1, {31'h0, q[0]});
	endtask : t_regs
	task automatic t_div;
		logic [31:0] q;
		wb(1'b1, OFS_SPI_DIVIDER, 32'h3, q);
		wb(1'b1, OFS_SERIAL_BASE, 32'h5, q);
		wb(1'b1, OFS_SERIAL_BASE + 8'h04, 32'h0, q);
		per(1, PCLK_DIV, "pclk");
		per(2, 10, "serial 0");
		per(3, 2, "serial 1");
		per(4, 6, "spi");
		wb(1'b1, OFS_PWR_MGMT_CTRL, 32'h15, q);
		per(0, 10, "sw ratio");
		wb(1'b1, OFS_PWR_MGMT_CTRL, 32'h3, q);
		per(0, 6, "low sw ratio");
		wb(1'b1, OFS_PWR_MGMT_CTRL, 32'h20, q);
	endtask : t_div
	// board reset with pins p; release delay, tick rate and capture
	task automatic t_boot(input logic [1:0] p, input int r);
		int n;
		logic [31:0] q;
		@(posedge clk);
		rqp <= p;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		wpulse(0, n);
		wpulse(0, n);
		chk("core held", 32'h0, {31'h0, core_n});
		n = 0;
		while (rpin_n !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (core_n !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		rng("release", N * r, (N + 1) * r + 3, n);
		per(0, r, "input tick");
		wb(1'b0, OFS_STATUS, 32'h0, q);
		chk("status", {22'h0, r[5:0], 1'b0, p, 1'b1}, q);
	endtask : t_boot
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_div;
		for (int k = 0; k < 4; k++) begin
			t_boot(k[1:0], rt[k]);
		end
		complete_run;
	end
	// a hang ends the run as a mismatch
	initial begin
		#500000;
		fails++;
		complete_run;
	end
endmodule : crr_top_tb
`default_nettype wire
